// ---- hw/parallel_port_handshake.sv ----
// Three-port parallel I/O unit with strobe/acknowledge handshakes on
// port C, reached over an AHB-Lite slave with zero wait states.
// Assumes all pin inputs are synchronous to hclk.
//
// Notes on behaviour
// - Mode 0: port C is two independent 4-bit plain I/O groups.
// - Modes 1 and 2 take port C lines for handshakes, rest plain.
// - Mode 1 input: C5 full A, C4 strobe A, C3 req A, B on C2-C0.
// - Mode 1 output: C7 full A, C6 ack A, C3 req A, B on C2-C0.
// - Mode 2 on group A: C7 C6 C5 C4 C3 handshake, B or plain on C2-C0.
// - Inputs paced by strobe and full; outputs by full and acknowledge.
// - Peripheral pulls strobe low; the device then latches port data.
// - Input full goes high once data is latched, acknowledging strobe.
// - Output full goes low after host writes the output port.
// - Service request goes high once a transfer completes, only when enabled.
`timescale 1ns/100ps
module parallel_port_handshake (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] first_data_port_in,
	output logic [7:0] first_data_port_out,
	output logic [7:0] first_data_port_oe,
	input wire logic [7:0] second_data_port_in,
	output logic [7:0] second_data_port_out,
	output logic [7:0] second_data_port_oe,
	input wire logic [7:0] handshake_port_lines_in,
	output logic [7:0] handshake_port_lines_out,
	output logic [7:0] handshake_port_lines_oe,
	output logic irq
);
	logic [pph_pkg::ctrl_width-1:0] ctrl_q;
	logic [7:0] pc_q;
	logic [pph_pkg::ev_width-1:0] stat_q;
	logic [pph_pkg::ev_width-1:0] irq_en_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [pph_pkg::ev_width-1:0] stat_d;

	xfer_if ch_a ();
	xfer_if ch_b ();

	// Bus decode.
	wire access = hsel & hready & htrans[1];
	wire rd_acc = access & ~hwrite;
	wire [7:0] raddr = {haddr[7:2], 2'b00};
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction
	wire wr_ctrl = wr_q & hit(addr_q, pph_pkg::ctrl_off);
	wire wr_a = wr_q & hit(addr_q, pph_pkg::port_a_off);
	wire wr_b = wr_q & hit(addr_q, pph_pkg::port_b_off);
	wire wr_c = wr_q & hit(addr_q, pph_pkg::port_c_off);
	wire wr_clr = wr_q & hit(addr_q, pph_pkg::irq_clr_off);
	wire wr_en = wr_q & hit(addr_q, pph_pkg::irq_en_off);

	// Mode decode.
	wire [1:0] a_mode = ctrl_q[pph_pkg::ctrl_a_mode_lsb +: 2];
	wire a_m1 = (a_mode == pph_pkg::a_mode1);
	wire a_m2 = (a_mode == pph_pkg::a_mode2);
	wire a_dir_in = ctrl_q[pph_pkg::ctrl_a_in];
	wire b_m1 = ctrl_q[pph_pkg::ctrl_b_mode1];
	wire b_dir_in = ctrl_q[pph_pkg::ctrl_b_in];
	wire a_in_en = (a_m1 & a_dir_in) | a_m2;
	wire a_out_en = (a_m1 & ~a_dir_in) | a_m2;
	wire b_in_en = b_m1 & b_dir_in;
	wire b_out_en = b_m1 & ~b_dir_in;

	// Port C line ownership per mode.
	wire [7:0] a_mask = a_m2 ? pph_pkg::a_bi_mask :
		(a_m1 ? (a_dir_in ? pph_pkg::a_in_mask :
		pph_pkg::a_out_mask) : 8'h00);
	wire [7:0] a_oe = a_m2 ? pph_pkg::a_bi_oe :
		(a_m1 ? (a_dir_in ? pph_pkg::a_in_oe : pph_pkg::a_out_oe) : 8'h00);
	wire [7:0] b_mask_w = b_m1 ? pph_pkg::b_mask : 8'h00;
	wire [7:0] b_oe = b_m1 ? (b_dir_in ? pph_pkg::b_in_oe :
		pph_pkg::b_out_oe) : 8'h00;
	wire [7:0] hs_mask = a_mask | b_mask_w;
	wire [7:0] hs_oe = a_oe | b_oe;
	// Plain lines follow one direction bit per 4-bit group.
	wire [7:0] gp_oe = {{4{ctrl_q[pph_pkg::ctrl_cu_out]}},
		{4{ctrl_q[pph_pkg::ctrl_cl_out]}}};
	wire inte_a = ctrl_q[pph_pkg::ctrl_inte_a];
	wire inte_b = ctrl_q[pph_pkg::ctrl_inte_b];

	// Handshake values placed on port C.
	logic [7:0] hs_val;
	always_comb begin
		hs_val = 8'h00;
		hs_val[pph_pkg::pc_a_obf] = ch_a.out_full_n;
		hs_val[pph_pkg::pc_a_ibf] = ch_a.in_full;
		hs_val[pph_pkg::pc_a_req] = ch_a.req & inte_a;
		hs_val[pph_pkg::pc_b_full] = b_dir_in ? ch_b.in_full :
			ch_b.out_full_n;
		hs_val[pph_pkg::pc_b_req] = ch_b.req & inte_b;
	end

	assign handshake_port_lines_out = (hs_mask & hs_val) | (~hs_mask & pc_q);
	assign handshake_port_lines_oe = (hs_mask & hs_oe) | (~hs_mask & gp_oe);

	// Channel A: strobe on C4, acknowledge on C6, data on the first port.
	assign ch_a.in_en = a_in_en;
	assign ch_a.out_en = a_out_en;
	assign ch_a.bidir = a_m2;
	assign ch_a.strobe_n = ~a_in_en |
		handshake_port_lines_in[pph_pkg::pc_a_stb];
	assign ch_a.ack_n = ~a_out_en |
		handshake_port_lines_in[pph_pkg::pc_a_ack];
	assign ch_a.din = first_data_port_in;
	assign ch_a.rd = rd_acc & hit(raddr, pph_pkg::port_a_off) & a_in_en;
	assign ch_a.wr = wr_a;
	assign ch_a.wdata = hwdata[7:0];

	// Channel B: strobe or acknowledge share C2.
	assign ch_b.in_en = b_in_en;
	assign ch_b.out_en = b_out_en;
	assign ch_b.bidir = 1'b0;
	assign ch_b.strobe_n = ~b_in_en |
		handshake_port_lines_in[pph_pkg::pc_b_stb_ack];
	assign ch_b.ack_n = ~b_out_en |
		handshake_port_lines_in[pph_pkg::pc_b_stb_ack];
	assign ch_b.din = second_data_port_in;
	assign ch_b.rd = rd_acc & hit(raddr, pph_pkg::port_b_off) & b_in_en;
	assign ch_b.wr = wr_b;
	assign ch_b.wdata = hwdata[7:0];

	xfer_channel u_chan_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.ch(ch_a)
	);
	xfer_channel u_chan_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.ch(ch_b)
	);

	// Data ports: plain in mode 0, channel driven in handshake modes.
	wire a_hs = a_m1 | a_m2;
	assign first_data_port_out = ch_a.out_data;
	assign first_data_port_oe = {8{a_hs ? ch_a.out_drive :
		ctrl_q[pph_pkg::ctrl_a_out]}};
	assign second_data_port_out = ch_b.out_data;
	assign second_data_port_oe = {8{b_m1 ? ch_b.out_drive :
		ctrl_q[pph_pkg::ctrl_b_out]}};

	// Events set sticky status; a set in the clearing cycle wins.
	wire [pph_pkg::ev_width-1:0] events = {ch_b.done_ev, ch_b.cap_ev,
		ch_a.done_ev, ch_a.cap_ev};
	assign stat_d = events | (stat_q & ~({4{wr_clr}} &
		hwdata[pph_pkg::ev_width-1:0]));

	// Read data, chosen in the address phase.
	wire [7:0] pc_rd = (hs_mask & hs_val) | (~hs_mask &
		((gp_oe & pc_q) | (~gp_oe & handshake_port_lines_in)));
	always_comb begin
		case (raddr)
			pph_pkg::ctrl_off: rdata_d = {21'h000000, ctrl_q};
			pph_pkg::port_a_off: rdata_d = {24'h000000,
				a_in_en ? ch_a.in_data : first_data_port_in};
			pph_pkg::port_b_off: rdata_d = {24'h000000,
				b_in_en ? ch_b.in_data : second_data_port_in};
			pph_pkg::port_c_off: rdata_d = {24'h000000, pc_rd};
			pph_pkg::irq_stat_off: rdata_d = {28'h0000000, stat_q};
			pph_pkg::irq_en_off: rdata_d = {28'h0000000, irq_en_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wr_q <= access & hwrite;
			addr_q <= raddr;
			if (rd_acc) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= pph_pkg::ctrl_reset;
			pc_q <= 8'h00;
			stat_q <= 4'h0;
			irq_en_q <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= hwdata[pph_pkg::ctrl_width-1:0];
			end
			if (wr_c) begin
				pc_q <= hwdata[7:0];
			end
			if (wr_en) begin
				irq_en_q <= hwdata[pph_pkg::ev_width-1:0];
			end
			stat_q <= stat_d;
		end
	end

	assign irq = |(stat_q & irq_en_q);
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

// ---- common/pph_pkg.sv ----
// Constants shared by the parallel port handshake block.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package pph_pkg;

	// Register byte offsets.
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] port_a_off = 8'h04;
	localparam logic [7:0] port_b_off = 8'h08;
	localparam logic [7:0] port_c_off = 8'h0c;
	localparam logic [7:0] irq_stat_off = 8'h10;
	localparam logic [7:0] irq_clr_off = 8'h14;
	localparam logic [7:0] irq_en_off = 8'h18;

	// Control register fields.
	localparam int ctrl_a_mode_lsb = 0;
	localparam int ctrl_a_in = 2;
	localparam int ctrl_b_mode1 = 3;
	localparam int ctrl_b_in = 4;
	localparam int ctrl_a_out = 5;
	localparam int ctrl_b_out = 6;
	localparam int ctrl_cu_out = 7;
	localparam int ctrl_cl_out = 8;
	localparam int ctrl_inte_a = 9;
	localparam int ctrl_inte_b = 10;
	localparam int ctrl_width = 11;
	localparam logic [10:0] ctrl_reset = 11'h000;

	// Group A mode encodings.
	localparam logic [1:0] a_mode0 = 2'h0;
	localparam logic [1:0] a_mode1 = 2'h1;
	localparam logic [1:0] a_mode2 = 2'h2;

	// Interrupt status bits.
	localparam int ev_a_in = 0;
	localparam int ev_a_out = 1;
	localparam int ev_b_in = 2;
	localparam int ev_b_out = 3;
	localparam int ev_width = 4;

	// Port C lines taken by handshakes, and those the block drives.
	localparam logic [7:0] a_in_mask = 8'h38;
	localparam logic [7:0] a_out_mask = 8'hc8;
	localparam logic [7:0] a_bi_mask = 8'hf8;
	localparam logic [7:0] b_mask = 8'h07;
	localparam logic [7:0] a_in_oe = 8'h28;
	localparam logic [7:0] a_out_oe = 8'h88;
	localparam logic [7:0] a_bi_oe = 8'ha8;
	localparam logic [7:0] b_in_oe = 8'h03;
	localparam logic [7:0] b_out_oe = 8'h03;

	// Port C line positions.
	localparam int pc_a_obf = 7;
	localparam int pc_a_ack = 6;
	localparam int pc_a_ibf = 5;
	localparam int pc_a_stb = 4;
	localparam int pc_a_req = 3;
	localparam int pc_b_stb_ack = 2;
	localparam int pc_b_full = 1;
	localparam int pc_b_req = 0;

endpackage

// ---- common/xfer_if.sv ----
// Signals between the register block and one transfer channel.
// Assumes both ends run on hclk.
`timescale 1ns/100ps
interface xfer_if;
	logic in_en;
	logic out_en;
	logic bidir;
	logic strobe_n;
	logic ack_n;
	logic [7:0] din;
	logic rd;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] in_data;
	logic [7:0] out_data;
	logic in_full;
	logic out_full_n;
	logic req;
	logic out_drive;
	logic cap_ev;
	logic done_ev;

	modport ctl(output in_en, out_en, bidir, strobe_n, ack_n, din, rd, wr,
		wdata, input in_data, out_data, in_full, out_full_n, req,
		out_drive, cap_ev, done_ev);
	modport chan(input in_en, out_en, bidir, strobe_n, ack_n, din, rd, wr,
		wdata, output in_data, out_data, in_full, out_full_n, req,
		out_drive, cap_ev, done_ev);
endinterface

// ---- hw/xfer_channel.sv ----
// One byte channel: input latch with strobe/full, output latch with
// full/acknowledge, and its service request.
// Assumes pin inputs are already synchronous to hclk.
`timescale 1ns/100ps
module xfer_channel (
	input wire logic hclk,
	input wire logic hresetn,
	xfer_if.chan ch
);
	logic stb_prev_q;
	logic [7:0] in_latch_q;
	logic [7:0] out_latch_q;
	logic in_full_q;
	logic out_full_q;
	logic out_req_q;
	wire stb_fall;
	wire capture;
	wire ack_low;
	wire done;

	assign stb_fall = ch.in_en & stb_prev_q & ~ch.strobe_n;
	// A strobe while the latch still holds unread data is ignored.
	assign capture = stb_fall & ~in_full_q;
	assign ack_low = ch.out_en & ~ch.ack_n;
	assign done = out_full_q & ack_low;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stb_prev_q <= 1'b1;
			in_latch_q <= 8'h00;
			out_latch_q <= 8'h00;
			in_full_q <= 1'b0;
			out_full_q <= 1'b0;
			out_req_q <= 1'b0;
		end else begin
			stb_prev_q <= ch.strobe_n;
			if (capture) begin
				in_latch_q <= ch.din;
			end
			if (ch.wr) begin
				out_latch_q <= ch.wdata;
			end
			in_full_q <= capture | (in_full_q & ~ch.rd);
			out_full_q <= (ch.wr & ch.out_en) | (out_full_q & ~ack_low);
			out_req_q <= done | (out_req_q & ~ch.wr);
		end
	end

	assign ch.in_data = in_latch_q;
	assign ch.out_data = out_latch_q;
	assign ch.in_full = in_full_q;
	assign ch.out_full_n = ~out_full_q;
	assign ch.req = (ch.in_en & in_full_q & ch.strobe_n)
		| (ch.out_en & out_req_q);
	// In bidirectional use the port drives only while acknowledge is low.
	assign ch.out_drive = ch.out_en & (~ch.bidir | ~ch.ack_n);
	assign ch.cap_ev = capture;
	assign ch.done_ev = done;
endmodule

// ---- bench/pph_monitor.sv ----
// Checker of the handshake block, seeing only the top-level ports.
// Assumes the single clock hclk and asynchronous reset hresetn.
`timescale 1ns/100ps
module pph_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [7:0] first_data_port_oe,
	input wire logic [7:0] handshake_port_lines_in,
	input wire logic [7:0] handshake_port_lines_out,
	input wire logic [7:0] handshake_port_lines_oe,
	input wire logic irq
);
	wire [7:0] ci = handshake_port_lines_in;
	wire [7:0] co = handshake_port_lines_out;
	wire [7:0] ce = handshake_port_lines_oe;
	wire take = hsel && hready && htrans[1];
	wire at_a = haddr[7:2] == pph_pkg::port_a_off[7:2];
	logic wr_q;
	logic wr_a_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wr_a_q <= 1'b0;
		end else begin
			wr_q <= take && hwrite;
			wr_a_q <= take && hwrite && at_a;
		end
	end
	default clocking mon_cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_wr_a;
		take && hwrite && at_a ##1 ce[7] && !ce[6];
	endsequence
	property p_obf_set;
		s_wr_a |=> !co[7];
	endproperty
	a_obf_set: assert property (p_obf_set)
		else $error("port write did not set output full");
	property p_ack_clr;
		ce[7] && !ce[6] && !co[7] && !ci[6] && !wr_a_q |-> ##[1:2] co[7];
	endproperty
	a_ack_clr: assert property (p_ack_clr)
		else $error("acknowledge did not release output full");
	property p_ibf_set;
		ce[5] && !ce[4] && !co[5] && $fell(ci[4]) |=> co[5];
	endproperty
	a_ibf_set: assert property (p_ibf_set)
		else $error("strobe did not set input full");
	property p_ibf_hold;
		$fell(co[5]) && ce[5] && $past(ce[5]) |-> $past(take && !hwrite && at_a);
	endproperty
	a_ibf_hold: assert property (p_ibf_hold)
		else $error("input full dropped without a port read");
	property p_irq_cause;
		$rose(irq) |-> $rose(co[5]) || $rose(co[7]) || $changed(co[1])
			|| $past(wr_q);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt rose without an event");
	property p_req_full;
		ce[7:4] == 4'h2 && co[3] |-> co[5];
	endproperty
	a_req_full: assert property (p_req_full)
		else $error("input request without full latch");
	property p_bidir_oe;
		ce[7:4] == 4'ha |-> first_data_port_oe == {8{!ci[6]}};
	endproperty
	a_bidir_oe: assert property (p_bidir_oe)
		else $error("port drive not tied to acknowledge");
	property p_out_oe;
		ce[7:4] == 4'h8 |-> first_data_port_oe == 8'hff;
	endproperty
	a_out_oe: assert property (p_out_oe)
		else $error("output port not driven");
endmodule
bind parallel_port_handshake pph_monitor i_pph_monitor (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hready, .first_data_port_oe,
	.handshake_port_lines_in, .handshake_port_lines_out,
	.handshake_port_lines_oe, .irq);

// ---- bench/pph_periph.sv ----
// Peripheral on ports A and C: strobes bytes in, acknowledges bytes out.
// Assumes pull-ups on undriven port C lines; released data is inverted.
`timescale 1ns/100ps
module pph_periph (
	input wire logic hclk,
	input wire logic [7:0] c_out,
	input wire logic [7:0] c_oe,
	input wire logic [7:0] a_out,
	input wire logic [7:0] a_oe,
	input wire logic [3:0] lag,
	output logic [7:0] c_in,
	output logic [7:0] a_in,
	output logic [7:0] got
);
	logic stb_n = 1'b1;
	logic ack_n = 1'b1;
	logic [7:0] drv = 8'h00;
	logic [3:0] cnt = 4'h0;
	assign c_in = (c_oe & c_out) | (~c_oe & {1'b1, ack_n, 1'b1, stb_n, 4'hf});
	assign a_in = (a_oe & a_out) | (~a_oe & drv);
	task automatic send(input logic [7:0] d);
		@(posedge hclk);
		drv <= d;
		stb_n <= 1'b0;
		repeat (3) @(posedge hclk);
		stb_n <= 1'b1;
		drv <= ~d;
		@(posedge hclk);
		#1;
	endtask
	always @(posedge hclk) begin
		if (!ack_n) begin
			got <= a_out;
			if (c_out[7])
				ack_n <= 1'b1;
		end else if (c_oe[7] && !c_oe[6] && !c_out[7]) begin
			cnt <= cnt + 4'h1;
			if (cnt >= lag) begin
				ack_n <= 1'b0;
				cnt <= 4'h0;
			end
		end
	end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the handshake block over AHB-Lite.
// Assumes the block answers with zero wait states.
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] lag = 4'h0;
	logic [7:0] b_in = 8'h69;
	wire [7:0] b_out, b_oe;
	logic [31:0] q;
	int failures = 0;
	int comparisons = 0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, irq;
	wire hready = hreadyout;
	wire [7:0] c_out, c_oe, c_in, a_out, a_oe, a_in, got;
	always #2.5 hclk = ~hclk;
	parallel_port_handshake i_parallel_port_handshake (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata,
		.hrdata, .hreadyout, .hresp, .first_data_port_in(a_in),
		.first_data_port_out(a_out), .first_data_port_oe(a_oe),
		.second_data_port_in(b_in), .second_data_port_out(b_out),
		.second_data_port_oe(b_oe), .handshake_port_lines_in(c_in),
		.handshake_port_lines_out(c_out), .handshake_port_lines_oe(c_oe),
		.irq);
	pph_periph i_pph_periph (.hclk, .c_out, .c_oe, .a_out, .a_oe, .lag,
		.c_in, .a_in, .got);
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		#1;
	endtask
	task automatic wait_ack;
		for (int i = 0; i < 40 && c_out[7] !== 1'b1; i++) begin
			@(posedge hclk);
			#1;
		end
		`CHK("ack wait", 1'b1, c_out[7])
	endtask
	task automatic t_reset;
		`CHK("oe", 8'h00, c_oe | a_oe)
		`CHK("bus", 2'h2, {hreadyout, hresp})
		bus(1'b0, pph_pkg::ctrl_off, 32'h0);
		`CHK("ctrl", 32'h0, q)
		bus(1'b0, 8'h1c, 32'h0);
		`CHK("unmapped", 32'h0, q)
	endtask
	task automatic t_mode0;
		bus(1'b1, pph_pkg::ctrl_off, 32'h180);
		bus(1'b1, pph_pkg::port_c_off, 32'ha5);
		`CHK("c out", 8'ha5, c_out)
		`CHK("c oe", 8'hff, c_oe)
		bus(1'b1, pph_pkg::ctrl_off, 32'h100);
		`CHK("c low oe", 8'h0f, c_oe)
	endtask
	task automatic t_in;
		bus(1'b1, pph_pkg::irq_en_off, 32'h1);
		bus(1'b1, pph_pkg::ctrl_off, 32'h205);
		`CHK("in oe", pph_pkg::a_in_oe, c_oe)
		i_pph_periph.send(8'h3c);
		`CHK("full req", 2'h3, {c_out[5], c_out[3]})
		`CHK("irq", 1'b1, irq)
		i_pph_periph.send(8'h77);
		bus(1'b0, pph_pkg::port_a_off, 32'h0);
		`CHK("port a", 32'h3c, q)
		`CHK("full req", 2'h0, {c_out[5], c_out[3]})
		bus(1'b0, pph_pkg::irq_stat_off, 32'h0);
		`CHK("stat", 32'h1, q)
		bus(1'b1, pph_pkg::irq_clr_off, 32'h1);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_out;
		bus(1'b1, pph_pkg::irq_en_off, 32'h2);
		bus(1'b1, pph_pkg::ctrl_off, 32'h201);
		`CHK("out oe", pph_pkg::a_out_oe, c_oe)
		lag = 4'h5;
		bus(1'b1, pph_pkg::port_a_off, 32'h5a);
		`CHK("obf", 1'b0, c_out[7])
		wait_ack();
		`CHK("taken", 8'h5a, got)
		`CHK("irq", 2'h3, {c_out[7], irq})
		`CHK("out req", 1'b1, c_out[3])
		lag = 4'h0;
		bus(1'b1, pph_pkg::port_a_off, 32'ha6);
		`CHK("req clr", 1'b0, c_out[3])
		wait_ack();
		`CHK("taken", 8'ha6, got)
		bus(1'b1, pph_pkg::irq_clr_off, 32'h2);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_bidir;
		bus(1'b1, pph_pkg::ctrl_off, 32'h1a);
		`CHK("bi oe", pph_pkg::a_bi_oe | pph_pkg::b_in_oe, c_oe)
		`CHK("a idle", 8'h00, a_oe)
		i_pph_periph.send(8'hc3);
		bus(1'b0, pph_pkg::port_a_off, 32'h0);
		`CHK("bi in", 32'hc3, q)
		bus(1'b1, pph_pkg::port_a_off, 32'h3e);
		wait_ack();
		`CHK("bi out", 8'h3e, got)
	endtask
	task automatic t_port_b;
		bus(1'b1, pph_pkg::ctrl_off, 32'h408);
		`CHK("b oe", pph_pkg::b_out_oe, c_oe)
		bus(1'b1, pph_pkg::port_b_off, 32'h96);
		`CHK("b out", 16'h96ff, {b_out, b_oe})
		`CHK("b full", 1'b0, c_out[1])
		bus(1'b1, pph_pkg::ctrl_off, 32'h0);
		bus(1'b0, pph_pkg::port_b_off, 32'h0);
		`CHK("b pins", 32'h69, q)
	endtask
	task end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		t_reset();
		t_mode0();
		t_in();
		t_out();
		t_bidir();
		t_port_b();
		end_of_test();
	end
	// The tests need well under a thousand cycles; ten thousand is a hang.
	initial begin
		#50000;
		failures++;
		end_of_test();
	end
endmodule
